//--- cpm_pkg.sv
// Purpose: constants, types and register layout of the clock and power mode controller
// Assumes: 100 MHz system clock, 8-bit register port with 4-bit address
// Notes:   cpm_cfg_t matches the clock select register byte bit for bit

package cpm_pkg;

    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned RC_STOP_LAT_NS  = 200;
    localparam int unsigned RC_STOP_LAT_CYC = (RC_STOP_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned VCO_RESET_MHZ   = 50;

    // ==========================================================
    // register offsets
    localparam logic [3:0] OFS_CLKSEL = 4'h0;
    localparam logic [3:0] OFS_OSCCTL = 4'h1;
    localparam logic [3:0] OFS_WDOG   = 4'h2;
    localparam logic [3:0] OFS_POSTDV = 4'h3;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_PLLMUL = 4'h5;

    // ==========================================================
    // field positions
    localparam int unsigned OSC_EN_BIT  = 0;
    localparam int unsigned REF_DIV_LSB = 4;
    localparam int unsigned REF_DIV_MSB = 7;
    localparam int unsigned DBGSTP_BIT  = 6;
    localparam int unsigned RATE_LSB    = 0;
    localparam int unsigned RATE_MSB    = 2;
    localparam int unsigned POSTDV_MSB  = 4;
    localparam int unsigned PLLMUL_MSB  = 5;

    // ==========================================================
    // reset values and maximum watchdog rate
    localparam logic [7:0] RST_CLKSEL   = 8'h80;
    localparam logic [4:0] RST_POSTDIV  = 5'h03;
    localparam logic [5:0] RST_PLLMUL   = 6'h18;
    localparam logic [2:0] WDOG_RATE_MAX = 3'h7;

    typedef enum logic [1:0] {
        ST_RUN      = 2'b00,
        ST_STOP_IN  = 2'b01,
        ST_STOP     = 2'b10,
        ST_STOP_OUT = 2'b11
    } cpm_state_t;

    typedef enum logic [1:0] {
        MODE_INT_PLL = 2'b00,
        MODE_EXT_PLL = 2'b01,
        MODE_BYPASS  = 2'b10,
        MODE_RSV     = 2'b11
    } cpm_mode_t;

    typedef enum logic [1:0] {
        SRC_IRC = 2'b00,
        SRC_OSC = 2'b01,
        SRC_RC  = 2'b10,
        SRC_OFF = 2'b11
    } cpm_src_t;

    typedef struct packed {
        logic pll_clock_select;
        logic pseudo_stop_select;
        logic rc_clock_stop_disable;
        logic watchdog_clock_select_hi;
        logic tick_pseudo_stop_enable;
        logic watchdog_pseudo_stop_enable;
        logic tick_clock_select;
        logic watchdog_clock_select_lo;
    } cpm_cfg_t;

    typedef struct packed {
        logic       pll_enable;
        logic       irc_enable;
        logic       osc_enable;
        logic       bus_clk_enable;
        cpm_mode_t  bus_clk_mode;
        logic       pll_ref_from_osc;
        logic       wakeup_enable;
        logic       lv_irq_enable;
        logic       lv_rst_enable;
        logic       por_enable;
        cpm_src_t   wdog_src;
        cpm_src_t   tick_src;
        logic       wdog_run;
        logic       tick_run;
        logic       wdog_force_max;
        logic [2:0] wdog_rate_eff;
    } cpm_ctl_t;

    localparam cpm_ctl_t RST_CTL = '{
        pll_enable: 1'b1, irc_enable: 1'b1, osc_enable: 1'b0, bus_clk_enable: 1'b1,
        bus_clk_mode: MODE_INT_PLL, pll_ref_from_osc: 1'b0, wakeup_enable: 1'b1,
        lv_irq_enable: 1'b1, lv_rst_enable: 1'b1, por_enable: 1'b1,
        wdog_src: SRC_IRC, tick_src: SRC_IRC, wdog_run: 1'b1, tick_run: 1'b1,
        wdog_force_max: 1'b0, wdog_rate_eff: 3'h0};

endpackage : cpm_pkg

//--- cpm_ctrl.sv
// Purpose: clock source, stop mode and debug freeze controller
// Assumes: all inputs synchronous to clk_sys; ce low freezes all state
// Notes:   outputs steer the analog clock tree and timer gates
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps

module cpm_ctrl (
    input  wire logic            clk_sys,
    input  wire logic            rst_b,
    input  wire logic            ce,
    input  wire logic [3:0]      reg_addr,
    input  wire logic [7:0]      reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic      [7:0]      reg_rdata,
    input  wire logic            stop_req,
    input  wire logic            wake_req,
    input  wire logic            debug_active,
    input  wire logic            oscillator_up,
    input  wire logic            pll_lock,
    input  wire logic            por_event,
    input  wire logic            lv_reset_event,
    input  wire logic            wdog_timeout,
    input  wire logic            clk_monitor_fail,
    input  wire logic            reset_pin_in,
    output logic                 reset_pin_out,
    output logic                 reset_pin_oe_b,
    output cpm_pkg::cpm_ctl_t    ctl,
    output logic      [3:0]      reference_divider,
    output logic      [4:0]      pll_post_div,
    output logic      [5:0]      pll_mult
);

    // ==========================================================
    // state
    typedef struct packed {
        cpm_pkg::cpm_state_t state;
        cpm_pkg::cpm_cfg_t   cfg;
        logic                crystal_osc_enable;
        logic [3:0]          ref_div;
        logic                debug_stop_timers;
        logic [2:0]          watchdog_rate;
        logic [4:0]          post_div;
        logic [5:0]          mult;
        logic                pseudo_latched;
        logic [7:0]          lat_cnt;
        logic [7:0]          rd_data;
        logic                pin_oe_b;
        cpm_pkg::cpm_ctl_t   ctl;
    } cpm_regs_t;

    localparam cpm_regs_t RST_REGS = '{
        state: cpm_pkg::ST_RUN,
        cfg: cpm_pkg::cpm_cfg_t'(cpm_pkg::RST_CLKSEL),
        crystal_osc_enable: 1'b0,
        ref_div: 4'h0,
        debug_stop_timers: 1'b0,
        watchdog_rate: 3'h0,
        post_div: cpm_pkg::RST_POSTDIV,
        mult: cpm_pkg::RST_PLLMUL,
        pseudo_latched: 1'b0,
        lat_cnt: 8'h00,
        rd_data: 8'h00,
        pin_oe_b: 1'b1,
        ctl: cpm_pkg::RST_CTL};

    localparam logic [7:0] LAT_LOAD = 8'(cpm_pkg::RC_STOP_LAT_CYC);

    cpm_regs_t s_r;
    cpm_regs_t s_nxt;

    // ==========================================================
    // next state
    always_comb begin
        logic run;
        logic held;
        logic freeze;
        logic rc_lat;
        run    = 1'b0;
        held   = 1'b0;
        freeze = 1'b0;
        rc_lat = 1'b0;
        s_nxt = s_r;
        s_nxt.rd_data = 8'h00;

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                cpm_pkg::OFS_CLKSEL: begin
                    s_nxt.cfg = cpm_pkg::cpm_cfg_t'(reg_wdata);
                end
                cpm_pkg::OFS_OSCCTL: begin
                    s_nxt.crystal_osc_enable = reg_wdata[cpm_pkg::OSC_EN_BIT];
                    s_nxt.ref_div = reg_wdata[cpm_pkg::REF_DIV_MSB:cpm_pkg::REF_DIV_LSB];
                end
                cpm_pkg::OFS_WDOG: begin
                    s_nxt.debug_stop_timers = reg_wdata[cpm_pkg::DBGSTP_BIT];
                    s_nxt.watchdog_rate = reg_wdata[cpm_pkg::RATE_MSB:cpm_pkg::RATE_LSB];
                end
                cpm_pkg::OFS_POSTDV: begin
                    s_nxt.post_div = reg_wdata[cpm_pkg::POSTDV_MSB:0];
                end
                cpm_pkg::OFS_PLLMUL: begin
                    s_nxt.mult = reg_wdata[cpm_pkg::PLLMUL_MSB:0];
                end
                default: begin
                end
            endcase
        end

        // register reads, data valid the following cycle only
        if (reg_rd) begin
            case (reg_addr)
                cpm_pkg::OFS_CLKSEL: s_nxt.rd_data = s_r.cfg;
                cpm_pkg::OFS_OSCCTL: s_nxt.rd_data = {s_r.ref_div, 3'h0, s_r.crystal_osc_enable};
                cpm_pkg::OFS_WDOG:   s_nxt.rd_data = {1'b0, s_r.debug_stop_timers, 3'h0,
                                                      s_r.watchdog_rate};
                cpm_pkg::OFS_POSTDV: s_nxt.rd_data = {3'h0, s_r.post_div};
                cpm_pkg::OFS_PLLMUL: s_nxt.rd_data = {2'h0, s_r.mult};
                cpm_pkg::OFS_STATUS: s_nxt.rd_data = {s_r.ctl.bus_clk_mode, debug_active,
                                                      reset_pin_in, s_r.pseudo_latched,
                                                      s_r.state != cpm_pkg::ST_RUN,
                                                      pll_lock, oscillator_up};
                default:             s_nxt.rd_data = 8'h00;
            endcase
        end

        // stop sequencing
        rc_lat = s_r.cfg.watchdog_clock_select_hi & s_r.cfg.rc_clock_stop_disable;
        case (s_r.state)
            cpm_pkg::ST_RUN: begin
                if (stop_req) begin
                    // kind of stop frozen here until the next stop request
                    s_nxt.pseudo_latched = s_r.cfg.pseudo_stop_select
                                         & s_r.crystal_osc_enable;
                    s_nxt.lat_cnt = rc_lat ? LAT_LOAD : 8'h00;
                    s_nxt.state = cpm_pkg::ST_STOP_IN;
                end
            end
            cpm_pkg::ST_STOP_IN: begin
                if (s_r.lat_cnt != 8'h00) begin
                    s_nxt.lat_cnt = s_r.lat_cnt - 8'h01;
                end else begin
                    s_nxt.state = cpm_pkg::ST_STOP;
                end
            end
            cpm_pkg::ST_STOP: begin
                if (wake_req) begin
                    if (!s_r.pseudo_latched) begin
                        s_nxt.cfg.pll_clock_select = 1'b1;
                        s_nxt.cfg.watchdog_clock_select_lo = 1'b0;
                        s_nxt.cfg.tick_clock_select = 1'b0;
                    end
                    s_nxt.lat_cnt = rc_lat ? LAT_LOAD : 8'h00;
                    s_nxt.state = cpm_pkg::ST_STOP_OUT;
                end
            end
            cpm_pkg::ST_STOP_OUT: begin
                if (s_r.lat_cnt != 8'h00) begin
                    s_nxt.lat_cnt = s_r.lat_cnt - 8'h01;
                end else begin
                    s_nxt.state = cpm_pkg::ST_RUN;
                end
            end
            default: begin
                s_nxt.state = cpm_pkg::ST_RUN;
            end
        endcase

        // internal reset sources pull the pin
        s_nxt.pin_oe_b = !(por_event | wdog_timeout | clk_monitor_fail
                         | (lv_reset_event & s_r.ctl.lv_rst_enable));

        // clock tree and timer gates, derived from next state
        run    = s_nxt.state == cpm_pkg::ST_RUN;
        held   = s_nxt.state == cpm_pkg::ST_STOP_IN || s_nxt.state == cpm_pkg::ST_STOP_OUT;
        freeze = debug_active & s_nxt.debug_stop_timers;
        s_nxt.ctl.pll_enable       = run;
        s_nxt.ctl.irc_enable       = run;
        s_nxt.ctl.bus_clk_enable   = run;
        s_nxt.ctl.wakeup_enable    = 1'b1;
        s_nxt.ctl.lv_irq_enable    = run;
        s_nxt.ctl.lv_rst_enable    = run;
        s_nxt.ctl.por_enable       = 1'b1;
        s_nxt.ctl.osc_enable       = s_nxt.crystal_osc_enable
                                   & (run | s_nxt.pseudo_latched);
        s_nxt.ctl.pll_ref_from_osc = s_nxt.crystal_osc_enable;
        if (!s_nxt.cfg.pll_clock_select) begin
            s_nxt.ctl.bus_clk_mode = cpm_pkg::MODE_BYPASS;
        end else if (s_nxt.crystal_osc_enable) begin
            s_nxt.ctl.bus_clk_mode = cpm_pkg::MODE_EXT_PLL;
        end else begin
            s_nxt.ctl.bus_clk_mode = cpm_pkg::MODE_INT_PLL;
        end

        if (s_nxt.cfg.watchdog_clock_select_hi) begin
            s_nxt.ctl.wdog_src = cpm_pkg::SRC_RC;
        end else if (run ? s_nxt.cfg.watchdog_clock_select_lo : s_nxt.pseudo_latched) begin
            s_nxt.ctl.wdog_src = cpm_pkg::SRC_OSC;
        end else begin
            s_nxt.ctl.wdog_src = cpm_pkg::SRC_IRC;
        end
        if (run ? s_nxt.cfg.tick_clock_select : s_nxt.pseudo_latched) begin
            s_nxt.ctl.tick_src = cpm_pkg::SRC_OSC;
        end else begin
            s_nxt.ctl.tick_src = cpm_pkg::SRC_IRC;
        end

        if (run) begin
            s_nxt.ctl.wdog_run = !freeze;
            s_nxt.ctl.tick_run = !freeze;
        end else begin
            if (s_nxt.cfg.watchdog_clock_select_hi) begin
                s_nxt.ctl.wdog_run = !s_nxt.cfg.rc_clock_stop_disable;
            end else begin
                s_nxt.ctl.wdog_run = s_nxt.pseudo_latched & !held
                                   & s_nxt.cfg.watchdog_pseudo_stop_enable;
            end
            s_nxt.ctl.tick_run = s_nxt.pseudo_latched & !held
                               & s_nxt.cfg.tick_pseudo_stop_enable;
        end

        // debug without freeze in run mode runs the watchdog at its longest period
        s_nxt.ctl.wdog_force_max = run & debug_active & !s_nxt.debug_stop_timers;
        s_nxt.ctl.wdog_rate_eff  = s_nxt.ctl.wdog_force_max ? cpm_pkg::WDOG_RATE_MAX
                                                            : s_nxt.watchdog_rate;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s_r <= RST_REGS;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign reg_rdata         = s_r.rd_data;
    assign reset_pin_out     = 1'b0;
    assign reset_pin_oe_b    = s_r.pin_oe_b;
    assign ctl               = s_r.ctl;
    assign reference_divider = s_r.ref_div;
    assign pll_post_div      = s_r.post_div;
    assign pll_mult          = s_r.mult;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence s_rc_stop_entry;
        ce && s_r.state == cpm_pkg::ST_RUN && stop_req
            && s_r.cfg.watchdog_clock_select_hi && s_r.cfg.rc_clock_stop_disable;
    endsequence

    sequence s_wake;
        ce && s_r.state == cpm_pkg::ST_STOP && wake_req;
    endsequence

    property p_reset_state;
        !$past(rst_b) |-> s_r.cfg.pll_clock_select && ctl.bus_clk_mode == cpm_pkg::MODE_INT_PLL
            && !ctl.pll_ref_from_osc && pll_post_div == cpm_pkg::RST_POSTDIV;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("reset clock state wrong");

    property p_run_on;
        s_r.state == cpm_pkg::ST_RUN |-> ctl.pll_enable && ctl.irc_enable
            && ctl.lv_irq_enable && ctl.lv_rst_enable && ctl.bus_clk_enable;
    endproperty
    a_run_on: assert property (p_run_on)
        else $error("run mode clocks or monitors off");

    property p_stop_off;
        s_r.state != cpm_pkg::ST_RUN |-> !ctl.pll_enable && !ctl.irc_enable
            && !ctl.bus_clk_enable && ctl.wakeup_enable;
    endproperty
    a_stop_off: assert property (p_stop_off)
        else $error("stop mode clocks still on");

    property p_stop_monitors;
        s_r.state != cpm_pkg::ST_RUN |-> !ctl.lv_irq_enable && !ctl.lv_rst_enable
            && ctl.por_enable;
    endproperty
    a_stop_monitors: assert property (p_stop_monitors)
        else $error("stop mode voltage monitors wrong");

    property p_stop_kind;
        (ce && s_r.state == cpm_pkg::ST_RUN && stop_req) |=>
            s_r.pseudo_latched == $past(s_r.cfg.pseudo_stop_select && s_r.crystal_osc_enable);
    endproperty
    a_stop_kind: assert property (p_stop_kind)
        else $error("stop kind latched wrong");

    property p_full_stop;
        s_r.state == cpm_pkg::ST_STOP && !s_r.pseudo_latched |->
            !ctl.osc_enable && !ctl.tick_run
            && (s_r.cfg.watchdog_clock_select_hi || !ctl.wdog_run);
    endproperty
    a_full_stop: assert property (p_full_stop)
        else $error("full stop left oscillator or timers running");

    property p_full_wake;
        (s_wake and !s_r.pseudo_latched) |=> s_r.cfg.pll_clock_select
            && !s_r.cfg.watchdog_clock_select_lo && !s_r.cfg.tick_clock_select;
    endproperty
    a_full_wake: assert property (p_full_wake)
        else $error("full stop wake select bits wrong");

    property p_pseudo_wake;
        (s_wake and s_r.pseudo_latched and !reg_wr) |=> $stable(s_r.cfg);
    endproperty
    a_pseudo_wake: assert property (p_pseudo_wake)
        else $error("pseudo stop wake altered select bits");

    property p_rc_source;
        s_r.cfg.watchdog_clock_select_hi |-> ctl.wdog_src == cpm_pkg::SRC_RC;
    endproperty
    a_rc_source: assert property (p_rc_source)
        else $error("watchdog left the rc clock");

    property p_rc_latency;
        s_rc_stop_entry |=> (s_r.state == cpm_pkg::ST_STOP_IN && !ctl.wdog_run)[*8];
    endproperty
    a_rc_latency: assert property (p_rc_latency)
        else $error("rc watchdog stop latency missing");

    property p_pseudo_timers;
        s_r.state == cpm_pkg::ST_STOP && s_r.pseudo_latched |->
            ctl.osc_enable && ctl.tick_run == s_r.cfg.tick_pseudo_stop_enable
            && (s_r.cfg.watchdog_clock_select_hi
                || ctl.wdog_run == s_r.cfg.watchdog_pseudo_stop_enable);
    endproperty
    a_pseudo_timers: assert property (p_pseudo_timers)
        else $error("pseudo stop timer gating wrong");

    property p_debug_freeze;
        (ce && s_r.state == cpm_pkg::ST_RUN && !stop_req && !reg_wr && debug_active
            && s_r.debug_stop_timers) |=> !ctl.wdog_run && !ctl.tick_run;
    endproperty
    a_debug_freeze: assert property (p_debug_freeze)
        else $error("timers not frozen in debug");

    property p_force_max;
        (ce && s_r.state == cpm_pkg::ST_RUN && !stop_req && !reg_wr && debug_active
            && !s_r.debug_stop_timers) |=> ctl.wdog_force_max
            && ctl.wdog_rate_eff == cpm_pkg::WDOG_RATE_MAX;
    endproperty
    a_force_max: assert property (p_force_max)
        else $error("watchdog not forced to maximum period");

    property p_reset_pin;
        (ce && (wdog_timeout || por_event || clk_monitor_fail)) |=> !reset_pin_oe_b;
    endproperty
    a_reset_pin: assert property (p_reset_pin)
        else $error("reset pin not driven on internal reset");

endmodule : cpm_ctrl

//--- testbench.sv
// Purpose: self-checking bench for the clock and power mode controller
// Assumes: bus, stop and debug timing as handed over for cpm_ctrl
// Notes:   random register traffic from a fixed seed, corner cases by hand
`timescale 1ns/1ps

module testbench;
    // ==========================================================
    // signals
    logic              clk_sys = 1'b0;
    logic              rst_b = 1'b0;
    logic              ce = 1'b1;
    logic [3:0]        reg_addr = 4'h0;
    logic [7:0]        reg_wdata = 8'h00;
    logic              reg_wr = 1'b0, reg_rd = 1'b0, stop_req = 1'b0, wake_req = 1'b0;
    logic              debug_active = 1'b0, oscillator_up = 1'b0, pll_lock = 1'b0;
    logic              por_event = 1'b0, lv_reset_event = 1'b0, wdog_timeout = 1'b0;
    logic              clk_monitor_fail = 1'b0, reset_pin_in = 1'b1;
    logic [7:0]        reg_rdata, rv, w;
    logic              reset_pin_out, reset_pin_oe_b;
    cpm_pkg::cpm_ctl_t ctl;
    logic [3:0]        reference_divider;
    logic [4:0]        pll_post_div;
    logic [5:0]        pll_mult;
    int                fails = 0, check_count = 0, seed = 51, n, lo;
    logic [7:0]        cfgs [7] = '{8'h03, 8'h13, 8'h33, 8'h4f, 8'h4b, 8'h5b, 8'h7b};

    cpm_ctrl u_dut (.clk_sys, .rst_b, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .stop_req, .wake_req, .debug_active, .oscillator_up, .pll_lock,
        .por_event, .lv_reset_event, .wdog_timeout, .clk_monitor_fail, .reset_pin_in,
        .reset_pin_out, .reset_pin_oe_b, .ctl, .reference_divider, .pll_post_div, .pll_mult);

    always #5 clk_sys = ~clk_sys;

    // ==========================================================
    // helpers
    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val

    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : step

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic pulse(input logic wake);
        @(posedge clk_sys);
        if (wake) wake_req <= 1'b1;
        else stop_req <= 1'b1;
        @(posedge clk_sys);
        wake_req <= 1'b0;
        stop_req <= 1'b0;
        #1;
    endtask : pulse

    function automatic logic exp_wdog_run(input logic [7:0] c);
        return c[4] ? !c[5] : (c[6] & c[2]);
    endfunction : exp_wdog_run

    function automatic logic [7:0] exp_wake_cfg(input logic [7:0] c, input logic ps);
        return ps ? c : ((c | 8'h80) & 8'hfc);
    endfunction : exp_wake_cfg

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        oscillator_up <= 1'b1;
        pll_lock <= 1'b1;
        step(1);
        chk_val("ctl_rst", cpm_pkg::RST_CTL, ctl);
        chk_val("postdiv_rst", 5'h03, pll_post_div);
        chk_val("oe_rst", 1, reset_pin_oe_b);
        rd(cpm_pkg::OFS_CLKSEL, rv);
        chk_val("clksel_rst", 8'h80, rv);
        wr(cpm_pkg::OFS_STATUS, 8'hff);
        rd(cpm_pkg::OFS_STATUS, rv);
        chk_val("status", 8'h13, rv);
        step(1);
        chk_val("rdata_idle", 0, reg_rdata);
        rd(4'hf, rv);
        chk_val("unmapped", 0, rv);
        wr(cpm_pkg::OFS_OSCCTL, 8'h01);
        chk_val("pee", {2'b11, cpm_pkg::MODE_EXT_PLL},
                {ctl.osc_enable, ctl.pll_ref_from_osc, ctl.bus_clk_mode});
        wr(cpm_pkg::OFS_CLKSEL, 8'h00);
        chk_val("pbe", {1'b1, cpm_pkg::MODE_BYPASS},
                {ctl.pll_enable, ctl.bus_clk_mode});
        // stop kinds: full, watchdog on rc clock, pseudo
        for (int i = 0; i < 7; i++) begin
            wr(cpm_pkg::OFS_CLKSEL, cfgs[i]);
            step(25);
            pulse(1'b0);
            // past any entry latency, into the settled stop state
            step(cpm_pkg::RC_STOP_LAT_CYC + 2);
            chk_val("stop_clk", 3'h0, {ctl.pll_enable, ctl.irc_enable, ctl.bus_clk_enable});
            chk_val("wakeup_en", 1, ctl.wakeup_enable);
            chk_val("lv_por", 3'h1,
                    {ctl.lv_irq_enable, ctl.lv_rst_enable, ctl.por_enable});
            chk_val("osc_en", cfgs[i][6], ctl.osc_enable);
            chk_val("tick_run", cfgs[i][6] & cfgs[i][3], ctl.tick_run);
            chk_val("wdog_run", exp_wdog_run(cfgs[i]), ctl.wdog_run);
            if (cfgs[i][4]) chk_val("wdog_src", cpm_pkg::SRC_RC, ctl.wdog_src);
            w = cfgs[i] ^ 8'h40;
            wr(cpm_pkg::OFS_CLKSEL, w);
            rd(cpm_pkg::OFS_STATUS, rv);
            chk_val("stop_kind", {cfgs[i][6], 1'b1}, rv[3:2]);
            step(25);
            pulse(1'b1);
            n = 0;
            while (ctl.bus_clk_enable !== 1'b1 && n < 40) begin
                step(1);
                n++;
            end
            lo = (cfgs[i][4] && cfgs[i][5]) ? cpm_pkg::RC_STOP_LAT_CYC : 1;
            chk_val("exit_lat", 1, n >= lo && n <= lo + 2);
            chk_val("run_on", 4'hf, {ctl.pll_enable, ctl.irc_enable,
                    ctl.lv_irq_enable, ctl.lv_rst_enable});
            if (!cfgs[i][6]) chk_val("tick_src", cpm_pkg::SRC_IRC, ctl.tick_src);
            rd(cpm_pkg::OFS_CLKSEL, rv);
            chk_val("wake_cfg", exp_wake_cfg(w, cfgs[i][6]), rv);
        end
        // debug freeze and forced longest watchdog period
        wr(cpm_pkg::OFS_WDOG, 8'h43);
        @(posedge clk_sys);
        debug_active <= 1'b1;
        step(2);
        chk_val("dbg_freeze", 3'h0, {ctl.wdog_run, ctl.tick_run, ctl.wdog_force_max});
        @(posedge clk_sys);
        debug_active <= 1'b0;
        step(2);
        chk_val("dbg_resume", 2'h3, {ctl.wdog_run, ctl.tick_run});
        wr(cpm_pkg::OFS_WDOG, 8'h03);
        @(posedge clk_sys);
        debug_active <= 1'b1;
        step(2);
        chk_val("dbg_max", {1'b1, cpm_pkg::WDOG_RATE_MAX},
                {ctl.wdog_force_max, ctl.wdog_rate_eff});
        @(posedge clk_sys);
        debug_active <= 1'b0;
        step(2);
        chk_val("rate", 4'h3, {ctl.wdog_force_max, ctl.wdog_rate_eff});
        // random pll setup traffic
        for (int i = 0; i < 8; i++) begin
            rv = 8'($random(seed));
            wr(cpm_pkg::OFS_POSTDV, rv);
            wr(cpm_pkg::OFS_PLLMUL, rv);
            wr(cpm_pkg::OFS_OSCCTL, {rv[7:4], 4'h1});
            chk_val("pll_setup", {rv[7:4], rv[4:0], rv[5:0]},
                    {reference_divider, pll_post_div, pll_mult});
            rd(cpm_pkg::OFS_POSTDV, w);
            chk_val("postdiv_rd", {3'h0, rv[4:0]}, w);
        end
        @(posedge clk_sys);
        ce <= 1'b0;
        wr(cpm_pkg::OFS_POSTDV, ~rv);
        @(posedge clk_sys);
        ce <= 1'b1;
        step(1);
        chk_val("ce_hold", rv[4:0], pll_post_div);
        // each internal reset source pulls the pin low
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            {por_event, lv_reset_event, wdog_timeout, clk_monitor_fail} <= 4'h8 >> i;
            step(2);
            chk_val("pin_drive", 2'h0, {reset_pin_oe_b, reset_pin_out});
            @(posedge clk_sys);
            {por_event, lv_reset_event, wdog_timeout, clk_monitor_fail} <= 4'h0;
            step(3);
            chk_val("pin_free", 1, reset_pin_oe_b);
        end
        final_report();
    end

    // ==========================================================
    // hang guard, about twenty-five times the expected run
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        final_report();
    end
endmodule : testbench
